// ==== logic/adcrt_top.sv ====
// Function
// - Conversion finish loads 10-bit result into low and high result bytes.
// - After low byte read, both result bytes are frozen until high read.
// - Left-adjusted high byte alone gives upper eight result bits.
// - Adjust clear: bits 9:8 at high 1:0, 7:0 in low byte.
// - Adjust set: bits 9:2 in high byte, 1:0 at low 7:6.
// - Trigger source field acts only while auto triggering enabled.
// - Auto mode starts conversion on each rising edge of chosen flag.
// - Switching from clear source to set source starts conversion if enabled.
// - Selecting free running code zero never makes a trigger event.
// - Codes: free, comparator, ext irq0, t0 match, t0 ovf, match B, t1 ovf, capture.
// - Each pin disable bit switches off that pin's digital input buffer.
// - Disabled pin reads zero in the port input register.
// - Adjust bit change alters result presentation immediately.
// - Complete flag sets when conversion finishes and result updates; here it also sets on a finish while the pair is frozen.
// - Writing one to auto trigger enable turns auto triggering on.
//
// Chosen here: the address map and the Wishbone slave port.
`include "adcrt_consts.svh"
module adcrt_top
  import adcrt_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [4:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Converter core
  input wire logic conv_done_in,
  input wire logic [9:0] conv_result_in,
  output logic conv_start_out,
  output logic conv_enable_out,
  output logic [4:0] channel_select_out,
  // Trigger flags from peripherals
  input wire adcrt_flags_t trig_flags_in,
  // Analog pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_buf_en_n_out
);

  // Reset release synchroniser
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Pin and flag synchronisers; first stage read only by second
  logic [14:0] async_meta;
  logic [14:0] async_sync;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      async_meta <= 15'h0000;
      async_sync <= 15'h0000;
    end else begin
      async_meta <= {trig_flags_in, pin_in};
      async_sync <= async_meta;
    end
  end
  logic [7:0] pin_sync;
  adcrt_flags_t flag_sync;
  assign pin_sync = async_sync[7:0];
  assign flag_sync = adcrt_flags_t'(async_sync[14:8]);

  // Register state
  logic [9:0] result;
  logic locked;
  logic done_flag;
  logic [7:0] trig_ctrl;
  logic [7:0] pin_dis;
  logic [7:0] conv_ctrl;
  logic [7:0] input_sel;
  logic src_prev;
  logic ack;
  logic [31:0] rdata;
  logic [9:0] next_result;
  logic next_locked;
  logic next_done_flag;
  logic [7:0] next_trig_ctrl;
  logic [7:0] next_pin_dis;
  logic [7:0] next_conv_ctrl;
  logic [7:0] next_input_sel;
  logic next_src_prev;
  logic next_ack;
  logic [31:0] next_rdata;

  // Bus decode; one wait state, ack drops the cycle after it is given
  logic access;
  logic wr;
  logic rd;
  assign access = wb_cyc_in && wb_stb_in && !ack;
  assign wr = access && wb_we_in && wb_sel_in[0];
  assign rd = access && !wb_we_in;

  // Result byte reads; the low read opens the lock window
  logic rd_low;
  logic rd_high;
  assign rd_low = rd && (wb_adr_in == `ADCRT_OFS_RES_LOW);
  assign rd_high = rd && (wb_adr_in == `ADCRT_OFS_RES_HIGH);

  // Result presentation follows adjust bit combinationally
  logic adjust;
  logic [7:0] low_view;
  logic [7:0] high_view;
  assign adjust = input_sel[`ADCRT_SEL_ADJ_BIT];
  always_comb begin
    if (adjust) begin
      low_view = {result[1:0], 6'h00};
      high_view = result[9:2];
    end else begin
      low_view = result[7:0];
      high_view = {6'h00, result[9:8]};
    end
  end

  // Trigger source selection
  logic [2:0] src_code;
  logic src_level;
  always_comb begin
    unique case (adcrt_src_t'(src_code))
      ADCRT_SRC_FREE: src_level = 1'b0;
      ADCRT_SRC_COMP: src_level = flag_sync.comparator;
      ADCRT_SRC_EXT0: src_level = flag_sync.ext_irq0;
      ADCRT_SRC_T0CM: src_level = flag_sync.t0_match;
      ADCRT_SRC_T0OV: src_level = flag_sync.t0_overflow;
      ADCRT_SRC_TCMB: src_level = flag_sync.t_match_b;
      ADCRT_SRC_T1OV: src_level = flag_sync.t1_overflow;
      ADCRT_SRC_T1CP: src_level = flag_sync.t1_capture;
    endcase
  end
  assign src_code = trig_ctrl[`ADCRT_TRIG_FIELD_MSB:0];

  // Start generation; free running retriggers on each completion
  logic auto_on;
  logic edge_hit;
  logic free_retrig;
  assign auto_on = conv_ctrl[`ADCRT_CTRL_EN_BIT] && conv_ctrl[`ADCRT_CTRL_AUTO_BIT];
  assign edge_hit = src_level && !src_prev;
  assign free_retrig = (src_code == `ADCRT_FREE_RUN) && conv_done_in;
  assign conv_start_out = auto_on && (edge_hit || free_retrig);
  assign conv_enable_out = conv_ctrl[`ADCRT_CTRL_EN_BIT];
  assign channel_select_out = input_sel[4:0];
  assign pin_buf_en_n_out = pin_dis;

  // Next-state for registers and bus
  always_comb begin
    next_result = result;
    next_locked = locked;
    next_done_flag = done_flag;
    next_trig_ctrl = trig_ctrl;
    next_pin_dis = pin_dis;
    next_conv_ctrl = conv_ctrl;
    next_input_sel = input_sel;
    next_src_prev = src_level;
    next_ack = access;
    next_rdata = 32'h0000_0000;
    if (rd) begin
      unique case (wb_adr_in)
        `ADCRT_OFS_RES_LOW: begin
          next_rdata = {24'h000000, low_view};
          next_locked = 1'b1;
        end
        `ADCRT_OFS_RES_HIGH: begin
          next_rdata = {24'h000000, high_view};
          next_locked = 1'b0;
        end
        `ADCRT_OFS_TRIG_SRC: next_rdata = {24'h000000, trig_ctrl};
        `ADCRT_OFS_PIN_DIS: next_rdata = {24'h000000, pin_dis};
        `ADCRT_OFS_CONV_CTRL: begin
          next_rdata = {24'h000000, conv_ctrl};
          next_rdata[`ADCRT_CTRL_FLAG_BIT] = done_flag;
        end
        `ADCRT_OFS_INPUT_SEL: next_rdata = {24'h000000, input_sel};
        `ADCRT_OFS_PORT_IN: next_rdata = {24'h000000, pin_sync & ~pin_dis};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      unique case (wb_adr_in)
        `ADCRT_OFS_TRIG_SRC: next_trig_ctrl = wb_dat_in[7:0] & `ADCRT_TRIG_WMASK;
        `ADCRT_OFS_PIN_DIS: next_pin_dis = wb_dat_in[7:0];
        `ADCRT_OFS_CONV_CTRL: begin
          next_conv_ctrl = wb_dat_in[7:0] & `ADCRT_CTRL_WMASK;
          if (wb_dat_in[`ADCRT_CTRL_FLAG_BIT]) begin
            next_done_flag = 1'b0;
          end
        end
        `ADCRT_OFS_INPUT_SEL: next_input_sel = wb_dat_in[7:0];
        default: next_input_sel = input_sel;
      endcase
    end
    // Completion: flag set wins over a same-cycle clear
    if (conv_done_in) begin
      next_done_flag = 1'b1;
      // A low read in this cycle returns the old byte, so keep the pair whole
      if (!locked && !rd_low) begin
        next_result = conv_result_in;
      end
    end
  end

  // Register update
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      result <= 10'h000;
      locked <= 1'b0;
      done_flag <= 1'b0;
      trig_ctrl <= `ADCRT_RST_BYTE;
      pin_dis <= `ADCRT_RST_BYTE;
      conv_ctrl <= `ADCRT_RST_BYTE;
      input_sel <= `ADCRT_RST_BYTE;
      src_prev <= 1'b0;
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      result <= next_result;
      locked <= next_locked;
      done_flag <= next_done_flag;
      trig_ctrl <= next_trig_ctrl;
      pin_dis <= next_pin_dis;
      conv_ctrl <= next_conv_ctrl;
      input_sel <= next_input_sel;
      src_prev <= next_src_prev;
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end
  assign wb_ack_out = ack;
  assign wb_dat_out = rdata;

  // Checks; a low read in the same cycle as a completion also freezes the pair
  chk_lock_freeze: assert property (@(posedge clk_in) disable iff (!rst_n)
    (locked || rd_low) && !rd_high |=> $stable(result))
    else $error("result changed while locked");
  chk_result_load: assert property (@(posedge clk_in) disable iff (!rst_n)
    conv_done_in && !locked && !rd_low |=> result == $past(conv_result_in))
    else $error("result not loaded on completion");
  chk_lock_set: assert property (@(posedge clk_in) disable iff (!rst_n)
    rd_low |=> locked)
    else $error("low read did not lock");
  chk_lock_release: assert property (@(posedge clk_in) disable iff (!rst_n)
    rd_high |=> !locked)
    else $error("lock not released by high read");
  chk_free_no_edge: assert property (@(posedge clk_in) disable iff (!rst_n)
    src_code == `ADCRT_FREE_RUN && !conv_done_in |-> !conv_start_out)
    else $error("free running made a trigger");
  chk_free_retrig: assert property (@(posedge clk_in) disable iff (!rst_n)
    auto_on && src_code == `ADCRT_FREE_RUN && conv_done_in |-> conv_start_out)
    else $error("free running did not restart");
  chk_auto_gate: assert property (@(posedge clk_in) disable iff (!rst_n)
    !conv_ctrl[`ADCRT_CTRL_AUTO_BIT] |-> !conv_start_out)
    else $error("trigger without auto enable");
  chk_enable_gate: assert property (@(posedge clk_in) disable iff (!rst_n)
    !conv_enable_out |-> !conv_start_out)
    else $error("trigger while converter disabled");
  chk_edge_start: assert property (@(posedge clk_in) disable iff (!rst_n)
    auto_on && $rose(src_level) && $stable(src_code) |-> conv_start_out)
    else $error("rising edge did not start");
  // Level alone must never start: only a change against the last cycle counts
  chk_start_on_rise: assert property (@(posedge clk_in) disable iff (!rst_n)
    auto_on && src_code != `ADCRT_FREE_RUN
      && !(src_level && !$past(src_level)) |-> !conv_start_out)
    else $error("start without a rising edge");
  chk_auto_write: assert property (@(posedge clk_in) disable iff (!rst_n)
    wr && wb_adr_in == `ADCRT_OFS_CONV_CTRL && wb_dat_in[`ADCRT_CTRL_AUTO_BIT]
      |=> conv_ctrl[`ADCRT_CTRL_AUTO_BIT])
    else $error("auto enable write lost");
  chk_reserved_zero: assert property (@(posedge clk_in) disable iff (!rst_n)
    rd && wb_adr_in == `ADCRT_OFS_TRIG_SRC |=> !wb_dat_out[7])
    else $error("reserved trigger bit read nonzero");
  chk_pin_disable: assert property (@(posedge clk_in) disable iff (!rst_n)
    wr && wb_adr_in == `ADCRT_OFS_PIN_DIS |=> pin_buf_en_n_out == $past(wb_dat_in[7:0]))
    else $error("pin buffer disable not applied");
  chk_port_mask: assert property (@(posedge clk_in) disable iff (!rst_n)
    rd && wb_adr_in == `ADCRT_OFS_PORT_IN |=> (wb_dat_out[7:0] & $past(pin_dis)) == 8'h00)
    else $error("disabled pin read nonzero");
  chk_left_view: assert property (@(posedge clk_in) disable iff (!rst_n)
    adjust |-> high_view == result[9:2] && low_view[5:0] == 6'h00)
    else $error("left adjust view wrong");
  chk_right_view: assert property (@(posedge clk_in) disable iff (!rst_n)
    !adjust |-> high_view[7:2] == 6'h00 && low_view == result[7:0])
    else $error("right adjust view wrong");
  chk_flag_set: assert property (@(posedge clk_in) disable iff (!rst_n)
    conv_done_in |=> done_flag)
    else $error("complete flag not set");
  chk_flag_read: assert property (@(posedge clk_in) disable iff (!rst_n)
    rd && wb_adr_in == `ADCRT_OFS_CONV_CTRL
      |=> wb_dat_out[`ADCRT_CTRL_FLAG_BIT] == $past(done_flag))
    else $error("complete flag read wrong");
  // Bus handshake: every taken request is answered next cycle, for one cycle
  chk_ack_answer: assert property (@(posedge clk_in) disable iff (!rst_n)
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("request not acknowledged");
  chk_ack_once: assert property (@(posedge clk_in) disable iff (!rst_n)
    wb_ack_out |=> !wb_ack_out)
    else $error("acknowledge held too long");
endmodule : adcrt_top

// ==== logic/adcrt_consts.svh ====
`ifndef ADCRT_CONSTS_SVH
`define ADCRT_CONSTS_SVH
// Register word offsets (byte addresses on the Wishbone bus)
`define ADCRT_OFS_RES_LOW 5'h00
`define ADCRT_OFS_RES_HIGH 5'h04
`define ADCRT_OFS_TRIG_SRC 5'h08
`define ADCRT_OFS_PIN_DIS 5'h0c
`define ADCRT_OFS_CONV_CTRL 5'h10
`define ADCRT_OFS_INPUT_SEL 5'h14
`define ADCRT_OFS_PORT_IN 5'h18
// Field positions and reset values
`define ADCRT_TRIG_FIELD_MSB 2
`define ADCRT_TRIG_WMASK 8'h47
`define ADCRT_CTRL_EN_BIT 7
`define ADCRT_CTRL_AUTO_BIT 5
`define ADCRT_CTRL_FLAG_BIT 4
// Only enable and auto bits are stored; bit 4 reads the complete flag, every other control bit reads zero
`define ADCRT_CTRL_WMASK 8'ha0
`define ADCRT_SEL_ADJ_BIT 5
`define ADCRT_RST_BYTE 8'h00
`define ADCRT_FREE_RUN 3'h0
`endif

// ==== logic/adcrt_pkg.sv ====
package adcrt_pkg;
  // Trigger source codes
  typedef enum logic [2:0] {
    ADCRT_SRC_FREE = 3'b000,
    ADCRT_SRC_COMP = 3'b001,
    ADCRT_SRC_EXT0 = 3'b010,
    ADCRT_SRC_T0CM = 3'b011,
    ADCRT_SRC_T0OV = 3'b100,
    ADCRT_SRC_TCMB = 3'b101,
    ADCRT_SRC_T1OV = 3'b110,
    ADCRT_SRC_T1CP = 3'b111
  } adcrt_src_t;

  // Wishbone request bundle
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [4:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } adcrt_wb_req_t;

  // Flags feeding the trigger mux, one per code 1..7
  typedef struct packed {
    logic t1_capture;
    logic t1_overflow;
    logic t_match_b;
    logic t0_overflow;
    logic t0_match;
    logic ext_irq0;
    logic comparator;
  } adcrt_flags_t;
endpackage : adcrt_pkg

// ==== dv/adcrt_core_model.sv ====
module adcrt_core_model (
  // Clock
  input wire logic clk_in,
  // Start request and value to hand back
  input wire logic start_in,
  input wire logic [9:0] value_in,
  // Completion
  output logic done_out,
  output logic [9:0] result_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] busy = 3'h0;
  // A conversion lasts three cycles; a new start restarts it
  always @(posedge clk_in) begin
    if (start_in) busy <= 3'h3;
    else if (busy != 3'h0) busy <= busy - 3'h1;
  end
  assign done_out = (busy == 3'h1);
  // Result is only valid beside done, so garble it elsewhere
  assign result_out = done_out ? value_in : ~value_in;
endmodule : adcrt_core_model

// ==== dv/adc_result_and_autotrigger_test.sv ====
module adc_result_and_autotrigger_test import adcrt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic adj; logic [9:0] v; logic [7:0] lo; logic [7:0] hi;} adcrt_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ack, start, done, en;
  logic [31:0] rdat;
  logic [9:0] val = 10'h000;
  logic [9:0] res;
  logic [7:0] pin = 8'h00;
  logic [7:0] buf_n;
  logic [7:0] q;
  logic [4:0] ch;
  adcrt_wb_req_t req = '0;
  adcrt_flags_t flags = '0;
  int n_errors = 0;
  int cmp_count = 0;
  int starts = 0;
  int s0;
  // Adjust, raw result, expected low and high bytes
  adcrt_row_t rows [5] = '{'{1'b0, 10'h3ff, 8'hff, 8'h03}, '{1'b0, 10'h2a5, 8'ha5, 8'h02},
    '{1'b1, 10'h3ff, 8'hc0, 8'hff}, '{1'b1, 10'h2a5, 8'h40, 8'ha9}, '{1'b1, 10'h001, 8'h40, 8'h00}};

  adcrt_top i_adcrt_top (.clk_in(clk), .rst_n_in(rst_n), .wb_cyc_in(req.cyc), .wb_stb_in(req.stb),
    .wb_we_in(req.we), .wb_adr_in(req.adr), .wb_sel_in(req.sel), .wb_dat_in(req.dat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .conv_done_in(done), .conv_result_in(res),
    .conv_start_out(start), .conv_enable_out(en), .channel_select_out(ch),
    .trig_flags_in(flags), .pin_in(pin), .pin_buf_en_n_out(buf_n));
  adcrt_core_model i_adcrt_core_model (.clk_in(clk), .start_in(start), .value_in(val),
    .done_out(done), .result_out(res));

  initial forever #10 clk = ~clk;
  // Start pulses seen by the converter
  always @(posedge clk) if (start === 1'b1) starts <= starts + 1;

  task automatic complete_run;
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One classic cycle; read data lands in q at the ack edge
  task automatic wb(input logic we, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b1, we, a, 4'h1, {24'h0, d}};
    @(posedge clk);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) n_errors++;
    q = rdat[7:0];
    req <= '0;
    @(posedge clk);
  endtask : wb

  // Comparator edge launches one conversion returning v
  task automatic conv(input logic [9:0] v);
    val <= v;
    flags <= 7'h01;
    repeat (8) @(posedge clk);
    flags <= 7'h00;
    repeat (4) @(posedge clk);
  endtask : conv

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int a = 0; a < 6; a++) begin
      wb(1'b0, 5'(a * 4), 8'h00);
      chk("reset value", q, 8'h00);
    end
    wb(1'b1, 5'h10, 8'ha0);
    wb(1'b1, 5'h08, 8'h01);
    chk("enable", {7'h00, en}, 8'h01);
    foreach (rows[i]) begin
      s0 = starts;
      wb(1'b1, 5'h14, {2'h0, rows[i].adj, 5'h00});
      conv(rows[i].v);
      chk("edge start", 8'(starts - s0), 8'h01);
      wb(1'b0, 5'h00, 8'h00);
      chk("low byte", q, rows[i].lo);
      wb(1'b0, 5'h04, 8'h00);
      chk("high byte", q, rows[i].hi);
    end
    wb(1'b0, 5'h10, 8'h00);
    chk("done flag", q, 8'hb0);
    // Writing one clears the flag; the unused control bit is not stored
    wb(1'b1, 5'h10, 8'hf0);
    wb(1'b0, 5'h10, 8'h00);
    chk("flag clear", q, 8'ha0);
    // Lock holds the pair, high read releases it
    wb(1'b1, 5'h14, 8'h00);
    conv(10'h155);
    wb(1'b0, 5'h00, 8'h00);
    chk("lock low", q, 8'h55);
    conv(10'h0aa);
    wb(1'b0, 5'h04, 8'h00);
    chk("lock high", q, 8'h01);
    conv(10'h0aa);
    wb(1'b0, 5'h00, 8'h00);
    chk("unlock low", q, 8'haa);
    wb(1'b1, 5'h14, 8'h25);
    wb(1'b0, 5'h04, 8'h00);
    chk("adjust now", q, 8'h2a);
    chk("channel", {3'h0, ch}, 8'h05);
    // Auto off: source edges do nothing
    wb(1'b1, 5'h10, 8'h80);
    s0 = starts;
    conv(10'h000);
    chk("auto off", 8'(starts - s0), 8'h00);
    // Auto on but converter off: edges must not start anything
    wb(1'b1, 5'h10, 8'h20);
    chk("enable off", {7'h00, en}, 8'h00);
    s0 = starts;
    conv(10'h000);
    chk("no enable", 8'(starts - s0), 8'h00);
    wb(1'b1, 5'h10, 8'ha0);
    for (int c = 1; c < 8; c++) begin
      wb(1'b1, 5'h08, 8'(c));
      s0 = starts;
      flags <= adcrt_flags_t'(7'h01 << (c - 1));
      repeat (8) @(posedge clk);
      flags <= '0;
      repeat (8) @(posedge clk);
      chk("source code", 8'(starts - s0), 8'h01);
    end
    // Switching onto a set flag counts as an edge, free running never
    flags <= 7'h02;
    repeat (4) @(posedge clk);
    s0 = starts;
    wb(1'b1, 5'h08, 8'h01);
    wb(1'b1, 5'h08, 8'h02);
    repeat (8) @(posedge clk);
    chk("switch edge", 8'(starts - s0), 8'h01);
    s0 = starts;
    wb(1'b1, 5'h08, 8'h00);
    repeat (8) @(posedge clk);
    chk("free switch", 8'(starts - s0), 8'h00);
    // Free running: one edge start, then code zero restarts on every completion
    wb(1'b1, 5'h08, 8'h01);
    flags <= 7'h01;
    repeat (3) @(posedge clk);
    s0 = starts;
    flags <= 7'h00;
    wb(1'b1, 5'h08, 8'h00);
    repeat (6) @(posedge clk);
    chk("free running", 8'(starts - s0), 8'h03);
    wb(1'b1, 5'h08, 8'h01);
    repeat (4) @(posedge clk);
    wb(1'b1, 5'h08, 8'h7f);
    wb(1'b0, 5'h08, 8'h00);
    chk("trigger reg", q, 8'h47);
    pin <= 8'hff;
    wb(1'b1, 5'h0c, 8'ha5);
    chk("buffer off", buf_n, 8'ha5);
    repeat (3) @(posedge clk);
    wb(1'b0, 5'h18, 8'h00);
    chk("port input", q, 8'h5a);
    wb(1'b0, 5'h1c, 8'h00);
    chk("unmapped", q, 8'h00);
    complete_run();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    complete_run();
  end
endmodule : adc_result_and_autotrigger_test
